// *** core/link_regs_map.vh ***
// Register offsets, field positions, reset values and timing counts
// for the port link control / link status register block.
// Assumes a 40 MHz core clock and 16-bit register words.
`ifndef LINK_REGS_MAP_VH
`define LINK_REGS_MAP_VH

// ----------------------------------------------------------------
// Offsets (byte addresses of the configuration space)
// ----------------------------------------------------------------
`define LR_ADDR_W 12
`define LR_OFS_CTL 12'h050
`define LR_OFS_STS 12'h052

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define LR_CTL_RETRAIN 5
`define LR_CTL_EXTENDED_SYNC 7
`define LR_CTL_CLKPM 8
`define LR_CTL_HW_AUTO_WIDTH_DISABLE 9
`define LR_CTL_BWM_IE 10
`define LR_CTL_ABW_IE 11

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define LR_STS_SPEED_LO 0
`define LR_STS_WIDTH_LO 4
`define LR_STS_TRAINING_ERROR 10
`define LR_STS_TRAIN 11
`define LR_STS_SCLK 12
`define LR_STS_DLLA 13
`define LR_STS_BWM 14
`define LR_STS_ABW 15

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define LR_SPEED_RST 4'h1
`define LR_SPEED_GEN1 4'h1
`define LR_SPEED_GEN2 4'h2
`define LR_W_X1 6'h01
`define LR_W_X2 6'h02
`define LR_W_X4 6'h04
`define LR_W_X8 6'h08
`define LR_W_X12 6'h0c
`define LR_W_X16 6'h10
`define LR_W_X32 6'h20

// ----------------------------------------------------------------
// Timing: upstream retrain delay and slot clock seeding wait
// ----------------------------------------------------------------
`define LR_CLK_HZ 40000000
`define LR_RETRAIN_DELAY_US 1000
`define LR_RETRAIN_DELAY_CYC ((`LR_CLK_HZ / 1000000) * `LR_RETRAIN_DELAY_US)
`define LR_SEED_WAIT 3'h4

`endif

// *** core/link_ctl_status_regs.v ***
// Link control (upper bits) and link status registers of one switch
// port. Assumes the LTSSM and data link layer run on clk, and that the
// two common-clock pins are asynchronous to clk.
`timescale 1ns/100ps
`include "link_regs_map.vh"

// How it works
// - Extended sync bit drives extra ordered sets on L0s exit and Recovery.
// - Clock power management enable reads zero, writes ignored.
// - Autonomous width disable reads zero; no autonomous width change exists.
// - Width reconfiguration requests pass regardless of the width disable bit.
// - Bandwidth management interrupt fires when its flag sets while enabled.
// - Autonomous bandwidth interrupt fires when its flag sets while enabled.
// - Both enables hardwired zero on upstream port or without notify capability.
// - Current speed bits 3:0, reset 1; 1 is 2.5G, 2 is 5G.
// - Negotiated width bits 9:4 carry the six-bit trained width code.
// - Unsupported max width setting is reported instead of the real width.
// - Supported max width but training failed reads width zero.
// - Training error bit is read-only, reported from the physical layer.
// - Training bit reads one while LTSSM in Configuration or Recovery.
// - Training bit also set after retrain write before training starts.
// - Training bit cleared when LTSSM leaves Configuration or Recovery.
// - Slot clock bit seeded from common-clock pin; EEPROM load overrides.
// - Data link active bit mirrors the data link active state.
// - Data link active never set when its capability bit is clear.
// - Retrain write sends LTSSM to Recovery; bit always reads zero.
// - Bandwidth flag set when software retrain completes without DL_Down.
module link_ctl_status_regs (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Register port
    input wire [`LR_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // Port configuration
    input wire is_upstream,
    input wire bw_notify_capable,
    input wire dll_active_capable,
    input wire [5:0] max_width_setting,
    // Common-clock pins
    input wire common_clock_up_pin,
    input wire common_clock_down_pin,
    // Serial EEPROM override of the slot clock bit
    input wire eeprom_sclk_wr,
    input wire eeprom_sclk_val,
    // LTSSM and data link layer
    input wire ltssm_in_config,
    input wire ltssm_in_recovery,
    input wire ltssm_l0s_exit,
    input wire [3:0] phy_speed,
    input wire [5:0] phy_width,
    input wire phy_train_fail,
    input wire phy_train_error,
    input wire dl_active_state,
    input wire dl_down,
    input wire width_reconfig_req,
    // Bandwidth status flags from the neighbouring status logic
    input wire bw_mgmt_flag,
    input wire auto_bw_flag,
    // Outputs to the link
    output wire retrain_to_recovery,
    output wire send_extra_sets,
    output wire width_reconfig_go,
    output wire retrain_done_ok,
    output reg bw_mgmt_irq,
    output reg auto_bw_irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    // Upstream retrain is held off this long; software sees its write
    // complete well before the link reacts
    localparam [31:0] DELAY_CYC = `LR_RETRAIN_DELAY_CYC;
    localparam [2:0] RT_IDLE = 3'b001;
    localparam [2:0] RT_WAIT = 3'b010;
    localparam [2:0] RT_TRAIN = 3'b100;

    reg extended_sync_q;
    reg bwm_ie_q;
    reg abw_ie_q;
    reg sclk_q;
    reg seeded_q;
    reg [2:0] cup_sync_q;
    reg [2:0] cdn_sync_q;
    reg cup_q;
    reg cdn_q;
    reg [2:0] rt_state_q;
    reg [2:0] rt_state_d;
    reg [31:0] dly_q;
    reg pend_q;
    reg down_seen_q;
    reg in_train_q;
    reg bwm_flag_q;
    reg abw_flag_q;
    reg retrain_pulse;
    reg retrain_ok;
    reg [5:0] width_code;
    reg width_supported;

    wire ltssm_training;
    wire ie_allowed;
    wire wr_ctl;
    wire retrain_wr;
    wire training_active;
    wire dll_active;
    wire bwm_ie_rd;
    wire abw_ie_rd;

    assign wr_ctl = reg_wr && (reg_addr == `LR_OFS_CTL);
    assign retrain_wr = wr_ctl && reg_wdata[`LR_CTL_RETRAIN];
    assign ltssm_training = ltssm_in_config || ltssm_in_recovery;

    assign ie_allowed = !is_upstream && bw_notify_capable;

    // Enables read back as zero the moment a strap forbids them,
    // not one cycle later when the stored copy is cleared
    assign bwm_ie_rd = bwm_ie_q && ie_allowed;
    assign abw_ie_rd = abw_ie_q && ie_allowed;

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extended_sync_q <= 1'b0;
            bwm_ie_q <= 1'b0;
            abw_ie_q <= 1'b0;
        end else if (wr_ctl) begin
            extended_sync_q <= reg_wdata[`LR_CTL_EXTENDED_SYNC];
            bwm_ie_q <= reg_wdata[`LR_CTL_BWM_IE] & ie_allowed;
            abw_ie_q <= reg_wdata[`LR_CTL_ABW_IE] & ie_allowed;
        end else if (!ie_allowed) begin
            // Strap changes also force the enables back to zero
            bwm_ie_q <= 1'b0;
            abw_ie_q <= 1'b0;
        end
    end

    assign send_extra_sets = extended_sync_q && (ltssm_l0s_exit || ltssm_in_recovery);

    assign width_reconfig_go = width_reconfig_req;

    // ----------------------------------------------------------------
    // Pin synchronisers and slot clock bit
    // ----------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cup_sync_q <= 3'b000;
            cdn_sync_q <= 3'b000;
            cup_q <= 1'b0;
            cdn_q <= 1'b0;
        end else begin
            cup_sync_q <= {cup_sync_q[1:0], common_clock_up_pin};
            cdn_sync_q <= {cdn_sync_q[1:0], common_clock_down_pin};
            // Only trust a level once stages two and three agree
            if (cup_sync_q[1] == cup_sync_q[2]) begin
                cup_q <= cup_sync_q[2];
            end
            if (cdn_sync_q[1] == cdn_sync_q[2]) begin
                cdn_q <= cdn_sync_q[2];
            end
        end
    end

    // Seeding waits for the synchronisers to fill after reset release;
    // the agreeing level lands one edge after stage three is loaded
    reg [2:0] settle_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_q <= 3'b000;
            seeded_q <= 1'b0;
            sclk_q <= 1'b0;
        end else begin
            if (settle_q != `LR_SEED_WAIT) begin
                settle_q <= settle_q + 3'b001;
            end
            if (eeprom_sclk_wr) begin
                sclk_q <= eeprom_sclk_val;
                seeded_q <= 1'b1;
            end else if (!seeded_q && settle_q == `LR_SEED_WAIT) begin
                sclk_q <= is_upstream ? cup_q : cdn_q;
                seeded_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Retrain sequencer
    // ----------------------------------------------------------------
    always @* begin
        rt_state_d = rt_state_q;
        retrain_pulse = 1'b0;
        retrain_ok = 1'b0;
        case (rt_state_q)
            RT_IDLE: begin
                if (retrain_wr && is_upstream) begin
                    rt_state_d = RT_WAIT;
                end else if (retrain_wr) begin
                    retrain_pulse = 1'b1;
                    rt_state_d = RT_TRAIN;
                end
            end
            RT_WAIT: begin
                if (dly_q == DELAY_CYC - 32'd1) begin
                    retrain_pulse = 1'b1;
                    rt_state_d = RT_TRAIN;
                end
            end
            RT_TRAIN: begin
                if (retrain_wr && !is_upstream) begin
                    retrain_pulse = 1'b1;
                end else if (in_train_q && !ltssm_training) begin
                    retrain_ok = !down_seen_q && !dl_down;
                    rt_state_d = RT_IDLE;
                end
            end
            default: begin
                rt_state_d = RT_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rt_state_q <= RT_IDLE;
            dly_q <= 32'd0;
            pend_q <= 1'b0;
            down_seen_q <= 1'b0;
            in_train_q <= 1'b0;
        end else begin
            rt_state_q <= rt_state_d;
            dly_q <= (rt_state_q == RT_WAIT) ? dly_q + 32'd1 : 32'd0;
            in_train_q <= ltssm_training;
            if (retrain_wr) begin
                pend_q <= 1'b1;
            end else if (ltssm_training) begin
                pend_q <= 1'b0;
            end
            if (rt_state_q == RT_IDLE) begin
                down_seen_q <= 1'b0;
            end else if (dl_down) begin
                down_seen_q <= 1'b1;
            end
        end
    end

    assign retrain_to_recovery = retrain_pulse;
    assign retrain_done_ok = retrain_ok;

    assign training_active = ltssm_training || pend_q;

    // ----------------------------------------------------------------
    // Interrupts on rising bandwidth flags
    // ----------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bwm_flag_q <= 1'b0;
            abw_flag_q <= 1'b0;
            bw_mgmt_irq <= 1'b0;
            auto_bw_irq <= 1'b0;
        end else begin
            bwm_flag_q <= bw_mgmt_flag;
            abw_flag_q <= auto_bw_flag;
            bw_mgmt_irq <= bwm_ie_q && bw_mgmt_flag && !bwm_flag_q;
            auto_bw_irq <= abw_ie_q && auto_bw_flag && !abw_flag_q;
        end
    end

    // ----------------------------------------------------------------
    // Width reporting
    // ----------------------------------------------------------------
    always @* begin
        case (max_width_setting)
            `LR_W_X1, `LR_W_X2, `LR_W_X4, `LR_W_X8, `LR_W_X12,
            `LR_W_X16, `LR_W_X32: width_supported = 1'b1;
            default: width_supported = 1'b0;
        endcase
        if (!width_supported) begin
            width_code = max_width_setting;
        end else if (phy_train_fail) begin
            width_code = 6'h00;
        end else begin
            width_code = phy_width;
        end
    end

    assign dll_active = dl_active_state && dll_active_capable;

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            // Unmapped addresses read zero
            reg_rdata <= 16'h0000;
            if (reg_addr == `LR_OFS_CTL) begin
                reg_rdata[`LR_CTL_EXTENDED_SYNC] <= extended_sync_q;
                reg_rdata[`LR_CTL_BWM_IE] <= bwm_ie_rd;
                reg_rdata[`LR_CTL_ABW_IE] <= abw_ie_rd;
            end else if (reg_addr == `LR_OFS_STS) begin
                reg_rdata[`LR_STS_SPEED_LO+3:`LR_STS_SPEED_LO] <= phy_speed;
                reg_rdata[`LR_STS_WIDTH_LO+5:`LR_STS_WIDTH_LO] <= width_code;
                reg_rdata[`LR_STS_TRAINING_ERROR] <= phy_train_error;
                reg_rdata[`LR_STS_TRAIN] <= training_active;
                reg_rdata[`LR_STS_SCLK] <= sclk_q;
                reg_rdata[`LR_STS_DLLA] <= dll_active;
                reg_rdata[`LR_STS_BWM] <= bw_mgmt_flag & ie_allowed;
                reg_rdata[`LR_STS_ABW] <= auto_bw_flag & ie_allowed;
            end
        end
    end

endmodule // link_ctl_status_regs

// *** tb/link_regs_props.sv ***
// Checker for the link control and status register block.
// Assumes it is bound into link_ctl_status_regs.
`timescale 1ns/100ps
module link_regs_props (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Register port
    input wire [11:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    // Straps and link side
    input wire is_upstream,
    input wire bw_notify_capable,
    input wire dll_active_capable,
    input wire ltssm_in_config,
    input wire ltssm_in_recovery,
    input wire ltssm_l0s_exit,
    input wire [3:0] phy_speed,
    input wire dl_active_state,
    input wire width_reconfig_req,
    input wire bw_mgmt_flag,
    // Outputs watched
    input wire retrain_to_recovery,
    input wire send_extra_sets,
    input wire width_reconfig_go,
    input wire retrain_done_ok,
    input wire bw_mgmt_irq
);
// ----------------------------------------
// Sequences and properties
// ----------------------------------------
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
sequence s_rd_ctl;
    reg_rd && reg_addr == 12'h050;
endsequence
sequence s_rd_sts;
    reg_rd && reg_addr == 12'h052;
endsequence
property p_ro_ctl;
    s_rd_ctl |=> (reg_rdata & 16'hf37f) == 16'h0000;
endproperty
a_ro_ctl: assert property (p_ro_ctl)
    else $error("control read shows a fixed-zero bit set");
property p_ie_gate;
    reg_rd && reg_addr == 12'h050 && (is_upstream || !bw_notify_capable)
        |=> reg_rdata[11:10] == 2'b00;
endproperty
a_ie_gate: assert property (p_ie_gate)
    else $error("bandwidth enables readable where hardwired");
property p_speed;
    s_rd_sts |=> reg_rdata[3:0] == $past(phy_speed);
endproperty
a_speed: assert property (p_speed)
    else $error("speed field differs from link speed");
property p_dlla;
    s_rd_sts |=> reg_rdata[13] == $past(dl_active_state && dll_active_capable);
endproperty
a_dlla: assert property (p_dlla)
    else $error("data link active bit wrong");
property p_train;
    s_rd_sts ##0 (ltssm_in_config || ltssm_in_recovery) |=> reg_rdata[11];
endproperty
a_train: assert property (p_train)
    else $error("training bit clear during training");
property p_retrain;
    reg_wr && reg_addr == 12'h050 && reg_wdata[5] && !is_upstream
        |-> retrain_to_recovery;
endproperty
a_retrain: assert property (p_retrain)
    else $error("retrain write gave no recovery request");
property p_extended_sync;
    send_extra_sets |-> ltssm_l0s_exit || ltssm_in_recovery;
endproperty
a_extended_sync: assert property (p_extended_sync)
    else $error("extra sets outside L0s exit or recovery");
property p_bw_irq;
    bw_mgmt_irq |-> $past(bw_mgmt_flag) && !$past(bw_mgmt_flag, 2)
        && !$past(is_upstream, 2);
endproperty
a_bw_irq: assert property (p_bw_irq)
    else $error("bandwidth interrupt without a flag rise");
property p_done;
    retrain_done_ok |-> $past(ltssm_in_config || ltssm_in_recovery)
        && !ltssm_in_config && !ltssm_in_recovery;
endproperty
a_done: assert property (p_done)
    else $error("retrain done outside training exit");
property p_width;
    width_reconfig_go == width_reconfig_req;
endproperty
a_width: assert property (p_width)
    else $error("width reconfiguration request blocked");
endmodule // link_regs_props
bind link_ctl_status_regs link_regs_props u_props (.clk, .arst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .is_upstream,
    .bw_notify_capable, .dll_active_capable, .ltssm_in_config,
    .ltssm_in_recovery, .ltssm_l0s_exit, .phy_speed, .dl_active_state,
    .width_reconfig_req, .bw_mgmt_flag, .retrain_to_recovery,
    .send_extra_sets, .width_reconfig_go, .retrain_done_ok, .bw_mgmt_irq);

// *** tb/link_partner_model.sv ***
// Stand-in for the LTSSM answering retrain requests.
// Assumes the bench sets lag and drop between retrains.
`timescale 1ns/100ps
module link_partner_model (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Bench control: wait before recovery, DL_Down in recovery
    input wire [3:0] lag,
    input wire drop,
    // From the block
    input wire retrain_to_recovery,
    // To the block
    output wire ltssm_in_config,
    output wire ltssm_in_recovery,
    output wire dl_down
);
reg [4:0] cnt_q;
// Recovery 3 cycles then configuration 2, after lag + 1 cycles
always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
        cnt_q <= 5'h0;
    else if (retrain_to_recovery)
        cnt_q <= {1'b0, lag} + 5'h6;
    else if (cnt_q != 5'h0)
        cnt_q <= cnt_q - 5'h1;
end
assign ltssm_in_recovery = cnt_q >= 5'h3 && cnt_q <= 5'h5;
assign ltssm_in_config = cnt_q == 5'h1 || cnt_q == 5'h2;
assign dl_down = drop && ltssm_in_recovery;
endmodule // link_partner_model

// *** tb/link_ctl_status_regs_bench.sv ***
// Self-checking bench for the link control and status registers.
// Assumes the partner model stands in for the LTSSM.
`timescale 1ns/100ps
module link_ctl_status_regs_bench;
logic clk, arst_n, reg_wr, reg_rd, is_upstream, bw_notify_capable, drop;
logic dll_active_capable, common_clock_up_pin, common_clock_down_pin;
logic eeprom_sclk_wr, eeprom_sclk_val, ltssm_in_config, ltssm_in_recovery;
logic ltssm_l0s_exit, phy_train_fail, phy_train_error, dl_active_state;
logic dl_down, width_reconfig_req, bw_mgmt_flag, auto_bw_flag, sclk_m;
logic retrain_to_recovery, send_extra_sets, width_reconfig_go;
logic retrain_done_ok, bw_mgmt_irq, auto_bw_irq;
logic [11:0] reg_addr;
logic [15:0] reg_wdata, reg_rdata, d;
logic [5:0] max_width_setting, phy_width;
logic [3:0] phy_speed, lag;
logic [5:0] wc [0:7];
integer mismatches, checked, seed, n_bw, n_ab, n_done, i, b0, a0;
link_ctl_status_regs uut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .is_upstream, .bw_notify_capable,
    .dll_active_capable, .max_width_setting, .common_clock_up_pin,
    .common_clock_down_pin, .eeprom_sclk_wr, .eeprom_sclk_val,
    .ltssm_in_config, .ltssm_in_recovery, .ltssm_l0s_exit, .phy_speed,
    .phy_width, .phy_train_fail, .phy_train_error, .dl_active_state,
    .dl_down, .width_reconfig_req, .bw_mgmt_flag, .auto_bw_flag,
    .retrain_to_recovery, .send_extra_sets, .width_reconfig_go,
    .retrain_done_ok, .bw_mgmt_irq, .auto_bw_irq);
link_partner_model far (.clk, .arst_n, .lag, .drop, .retrain_to_recovery,
    .ltssm_in_config, .ltssm_in_recovery, .dl_down);
initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
end
always @(posedge clk) begin
    n_bw <= n_bw + bw_mgmt_irq;
    n_ab <= n_ab + auto_bw_irq;
    n_done <= n_done + retrain_done_ok;
end
// ----------------------------------------
// Model and tasks
// ----------------------------------------
function [15:0] sts_exp(input tr);
    logic [5:0] w;
    logic g;
    begin
        g = !is_upstream && bw_notify_capable;
        w = phy_train_fail ? 6'h00 : phy_width;
        case (max_width_setting)
            6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20: ;
            default: w = max_width_setting;
        endcase
        sts_exp = {g & auto_bw_flag, g & bw_mgmt_flag,
            dll_active_capable & dl_active_state, sclk_m, tr,
            phy_train_error, w, phy_speed};
    end
endfunction
task chk(input [15:0] g, input [15:0] e);
    begin
        checked = checked + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    end
endtask
task wr(input [11:0] a, input [15:0] v);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    end
endtask
task rd(input [11:0] a, input [15:0] e);
    begin
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    end
endtask
task conclude;
    begin
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
endtask
initial begin
    repeat (50000) @(posedge clk);
    mismatches = mismatches + 1;
    conclude;
end
// ----------------------------------------
// Scenarios
// ----------------------------------------
initial begin
    seed = 32'hc5ad_191e;
    {mismatches, checked, n_bw, n_ab, n_done} = 0;
    wc = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20, 6'h03};
    {reg_wr, reg_rd, is_upstream, eeprom_sclk_wr, eeprom_sclk_val, drop,
        ltssm_l0s_exit, phy_train_fail, phy_train_error, arst_n,
        width_reconfig_req, bw_mgmt_flag, auto_bw_flag,
        common_clock_up_pin} = 14'h0000;
    {bw_notify_capable, dll_active_capable, dl_active_state,
        common_clock_down_pin, sclk_m} = 5'h1f;
    {reg_addr, reg_wdata, lag} = 32'h0000_0000;
    {max_width_setting, phy_width, phy_speed} = 16'h1041;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(12'h050, 16'h0000);
    rd(12'h052, sts_exp(1'b0));
    @(posedge clk);
    eeprom_sclk_wr <= 1'b1;
    @(posedge clk);
    eeprom_sclk_wr <= 1'b0;
    sclk_m = 1'b0;
    rd(12'h052, sts_exp(1'b0));
    rd(12'h054, 16'h0000);
    for (i = 0; i < 12; i = i + 1) begin
        d = $random(seed);
        @(posedge clk);
        is_upstream <= d[0];
        bw_notify_capable <= d[1];
        d = $random(seed) & 16'hffdf;
        wr(12'h050, d);
        rd(12'h050, d & (is_upstream | !bw_notify_capable ? 16'h0080
            : 16'h0c80));
    end
    for (i = 0; i < 16; i = i + 1) begin
        d = $random(seed);
        @(posedge clk);
        phy_speed <= d[0] ? 4'h2 : 4'h1;
        max_width_setting <= wc[d[3:1]];
        phy_width <= wc[d[6:4] % 7];
        {phy_train_fail, phy_train_error, dl_active_state} <= d[9:7];
        {dll_active_capable, is_upstream, bw_mgmt_flag} <= d[12:10];
        {auto_bw_flag, width_reconfig_req} <= d[14:13];
        #1 rd(12'h052, sts_exp(1'b0));
        chk({15'h0000, width_reconfig_go}, {15'h0000, d[13]});
    end
    @(posedge clk);
    is_upstream <= 1'b0;
    bw_notify_capable <= 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
        wr(12'h050, i ? 16'h0000 : 16'h0c00);
        {bw_mgmt_flag, auto_bw_flag} <= 2'h0;
        repeat (3) @(posedge clk);
        b0 = n_bw;
        a0 = n_ab;
        {bw_mgmt_flag, auto_bw_flag} <= 2'h3;
        repeat (4) @(posedge clk);
        #1 chk(16'(n_bw - b0), i ? 16'h0000 : 16'h0001);
        chk(16'(n_ab - a0), i ? 16'h0000 : 16'h0001);
    end
    for (i = 0; i < 2; i = i + 1) begin
        wr(12'h050, i ? 16'h0000 : 16'h0080);
        ltssm_l0s_exit <= 1'b1;
        @(posedge clk);
        #1 chk({15'h0000, send_extra_sets}, i ? 16'h0000 : 16'h0001);
        ltssm_l0s_exit <= 1'b0;
    end
    // Slow partner first, then prompt one with DL_Down in recovery
    for (i = 0; i < 2; i = i + 1) begin
        lag <= i ? 4'h0 : 4'h8;
        drop <= i[0];
        b0 = n_done;
        wr(12'h050, 16'h0020);
        rd(12'h050, 16'h0000);
        rd(12'h052, sts_exp(1'b1));
        repeat (30) @(posedge clk);
        #1 rd(12'h052, sts_exp(1'b0));
        chk(16'(n_done - b0), i ? 16'h0000 : 16'h0001);
    end
    // Upstream retrain: bit reads one at once, Recovery 1 ms later
    @(posedge clk);
    is_upstream <= 1'b1;
    {drop, lag} <= 5'h00;
    b0 = n_done;
    wr(12'h050, 16'h0020);
    rd(12'h052, sts_exp(1'b1));
    i = 3;
    while (retrain_to_recovery !== 1'b1 && i < 45000) begin
        @(posedge clk);
        #1 i = i + 1;
    end
    chk(i[15:0], 16'h9c40);
    repeat (30) @(posedge clk);
    rd(12'h052, sts_exp(1'b0));
    chk(16'(n_done - b0), 16'h0001);
    conclude;
end
endmodule // link_ctl_status_regs_bench
